// file: src/remote_limit_pkg.sv
// How it works
// [R01] low threshold is 11 bits: high byte plus low byte bits 7:5, resets 0
// [R02] low byte bits 4:0 do nothing and read as zero
// [R03] critical limit is an 8-bit integer resetting to 110 degrees
// [R04] writing the limit while override is clear locks the value against later writes
// [R05] with unsigned format clear, limit bit 7 is a sign bit
// [R06] critical output holds until temperature drops below limit minus hysteresis
// [R07] hysteresis bits 6:0 weigh 64 down to 1 degree, plain binary
// [R08] hysteresis bit 7 accepts any write and changes nothing
// [R09] filter field 00 off, 01 and 10 minimal, 11 enhanced
// [R10] comparator mode makes alert follow the live alarm conditions
// [R11] host writes zeros to filter register bits 7:6
// [R12] filter register bits 5:3 read as zero
// [R13] temperature below low threshold sets low flag and alert
// [R14] temperature above critical limit sets critical flag, alert and critical output
// [R15] flags stay set until a status read finds their condition gone
// [R16] comparisons are evaluated on each completed conversion
package remote_limit_pkg;

    // register offsets
    localparam logic [7:0] LOW_HI_OFS = 8'h08;
    localparam logic [7:0] LOW_LO_OFS = 8'h14;
    localparam logic [7:0] CRIT_OFS   = 8'h19;
    localparam logic [7:0] HYST_OFS   = 8'h21;
    localparam logic [7:0] FILT_OFS   = 8'hBF;

    // reset values
    localparam logic [7:0] LOW_HI_RST = 8'h00;
    localparam logic [2:0] LOW_LO_RST = 3'h0;
    localparam logic [7:0] CRIT_RST   = 8'h6E;
    localparam logic [6:0] HYST_RST   = 7'h0A;
    localparam logic [1:0] FILT_RST   = 2'h0;

    // field positions
    localparam int LOW_LO_MSB   = 7;
    localparam int LOW_LO_LSB   = 5;
    localparam int HYST_MSB     = 6;
    localparam int FILT_MSB     = 2;
    localparam int FILT_LSB     = 1;
    localparam int FRSV_MSB     = 7;
    localparam int FRSV_LSB     = 6;
    localparam int CMP_MODE_BIT = 0;

    // fixed point: 10 integer bits with sign, 3 fraction bits
    localparam int FIX_W  = 13;
    localparam int TEMP_W = 12;

    typedef enum logic [1:0] {
        FILT_OFF,
        FILT_MIN,
        FILT_MAX
    } filter_level_t;

    // whole-degree byte to fixed point, sign honoured only when asked
    function automatic logic signed [12:0] byte_to_fix(input logic [7:0] v, input logic is_signed);
        return {{2{is_signed & v[7]}}, v, 3'h0};
    endfunction : byte_to_fix

    // eleven-bit signed reading (1/8 degree) to fixed point
    function automatic logic signed [12:0] low_to_fix(input logic [10:0] v);
        return {{2{v[10]}}, v};
    endfunction : low_to_fix

    function automatic filter_level_t decode_filter(input logic [1:0] f);
        case (f)
            2'h0:    return FILT_OFF;
            2'h3:    return FILT_MAX;
            default: return FILT_MIN;
        endcase
    endfunction : decode_filter

endpackage : remote_limit_pkg

// file: src/limit_cmp_if.sv
`timescale 1ns/1ps
interface limit_cmp_if;
    logic                eval;
    logic signed [12:0]  temp;
    logic signed [12:0]  low_lim;
    logic signed [12:0]  crit_lim;
    logic [6:0]          hyst;
    logic                done;
    logic                low_cond;
    logic                crit_cond;
    logic                crit_hold;

    modport bank (output eval, temp, low_lim, crit_lim, hyst,
                  input  done, low_cond, crit_cond, crit_hold);
    modport cmp  (input  eval, temp, low_lim, crit_lim, hyst,
                  output done, low_cond, crit_cond, crit_hold);
endinterface : limit_cmp_if

// file: src/limit_compare.sv
`timescale 1ns/1ps
module limit_compare (
    // clock and reset
    input  wire logic  mclk_i,
    input  wire logic  rst_i,
    // operands and results
    limit_cmp_if.cmp   lc
);

    typedef struct packed {
        logic done;
        logic low_cond;
        logic crit_cond;
        logic crit_hold;
    } cmp_state_t;

    cmp_state_t         st_ff;
    cmp_state_t         nxt_st;
    logic signed [13:0] release_lvl;

    // one bit wider so the subtraction never wraps
    assign release_lvl = 14'(lc.crit_lim) - 14'(signed'({1'b0, lc.hyst, 3'h0}));

    // all three comparisons happen together on a finished conversion
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        // [R16] evaluate per conversion
        if (lc.eval) begin
            nxt_st.done      = 1'b1;
            // [R13] below low threshold
            nxt_st.low_cond  = lc.temp < lc.low_lim;
            // [R14] above critical limit
            nxt_st.crit_cond = lc.temp > lc.crit_lim;
            // [R06] hysteresis release
            if (lc.temp > lc.crit_lim) begin
                nxt_st.crit_hold = 1'b1;
            end else if (14'(lc.temp) < release_lvl) begin
                nxt_st.crit_hold = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lc.done      = st_ff.done;
    assign lc.low_cond  = st_ff.low_cond;
    assign lc.crit_cond = st_ff.crit_cond;
    assign lc.crit_hold = st_ff.crit_hold;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_eval_latency: assert property (lc.eval |=> lc.done) // [R16]
        else $error("compare result not produced one cycle after conversion");
    a_low_compare: assert property (lc.eval |=> lc.low_cond == $past(lc.temp < lc.low_lim)) // [R13]
        else $error("low condition does not match threshold compare");
    a_crit_hold_band: assert property (lc.crit_hold && lc.eval && (14'(lc.temp) >= release_lvl)
                                       |=> lc.crit_hold) // [R06]
        else $error("critical output released inside hysteresis band");
    a_crit_release: assert property (lc.eval && (14'(lc.temp) < release_lvl)
                                     && !(lc.temp > lc.crit_lim) |=> !lc.crit_hold) // [R06]
        else $error("critical output not released below limit minus hysteresis");

endmodule : limit_compare

// file: src/remote_temp_limit_regs.sv
`timescale 1ns/1ps
module remote_temp_limit_regs (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // register port from the serial interface engine
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic [7:0]        reg_rdata_o,
    // configuration bits held elsewhere
    input  wire logic         limit_override_i,
    input  wire logic         unsigned_format_select_i,
    // conversion results
    input  wire logic         conv_done_i,
    input  wire logic [11:0]  remote_temp_i,
    // status register read strobe
    input  wire logic         status_rd_i,
    // alarm outputs
    output logic              remote_low_alarm_flag_o,
    output logic              remote_critical_alarm_flag_o,
    output logic              alert_o,
    output logic              critical_output_o,
    // mode outputs
    output logic [1:0]        filter_level_select_o,
    output logic              comparator_mode_select_o,
    output logic              critical_limit_locked_o
);

    typedef struct packed {
        logic [7:0] low_limit_upper_bits;
        logic [2:0] low_limit_lower_bits;
        logic [7:0] critical_limit_bits;
        logic [6:0] critical_hysteresis_bits;
        logic [1:0] filt_spare;
        logic [1:0] filter_level_select;
        logic       comparator_mode_select;
        logic       crit_locked;
        logic       low_flag;
        logic       crit_flag;
        logic       alert;
        logic       crit_out;
        logic [1:0] filt_level;
        logic [7:0] rdata;
    } bank_state_t;

    bank_state_t st_ff;
    bank_state_t nxt_st;
    logic        wr_low_hi;
    logic        wr_low_lo;
    logic        wr_crit;
    logic        wr_hyst;
    logic        wr_filt;
    logic [7:0]  rd_mux;

    limit_cmp_if lc ();

    limit_compare u_compare (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .lc     (lc.cmp)
    );

    // write decode
    assign wr_low_hi = reg_wr_i && (reg_addr_i == remote_limit_pkg::LOW_HI_OFS);
    assign wr_low_lo = reg_wr_i && (reg_addr_i == remote_limit_pkg::LOW_LO_OFS);
    assign wr_crit   = reg_wr_i && (reg_addr_i == remote_limit_pkg::CRIT_OFS);
    assign wr_hyst   = reg_wr_i && (reg_addr_i == remote_limit_pkg::HYST_OFS);
    assign wr_filt   = reg_wr_i && (reg_addr_i == remote_limit_pkg::FILT_OFS);

    // operands to the comparator: conversion inputs plus limits taken from live register contents
    assign lc.eval     = conv_done_i;
    assign lc.temp     = 13'(signed'(remote_temp_i));
    // [R01] signed eleven-bit threshold
    assign lc.low_lim  = remote_limit_pkg::low_to_fix({st_ff.low_limit_upper_bits, st_ff.low_limit_lower_bits});
    // [R05] sign only in signed format
    assign lc.crit_lim = remote_limit_pkg::byte_to_fix(st_ff.critical_limit_bits, !unsigned_format_select_i);
    // [R07] binary degree weights
    assign lc.hyst     = st_ff.critical_hysteresis_bits;

    // read data mux; unmapped offsets answer zero
    always_comb begin
        case (reg_addr_i)
            remote_limit_pkg::LOW_HI_OFS: rd_mux = st_ff.low_limit_upper_bits;
            // [R02] unused low bits zero
            remote_limit_pkg::LOW_LO_OFS: rd_mux = {st_ff.low_limit_lower_bits, 5'h00};
            remote_limit_pkg::CRIT_OFS:   rd_mux = st_ff.critical_limit_bits;
            remote_limit_pkg::HYST_OFS:   rd_mux = {1'b0, st_ff.critical_hysteresis_bits};
            // [R12] middle bits zero
            remote_limit_pkg::FILT_OFS:   rd_mux = {st_ff.filt_spare, 3'h0, st_ff.filter_level_select,
                                                    st_ff.comparator_mode_select};
            default:                      rd_mux = 8'h00;
        endcase
    end

    // next state of the whole bank
    always_comb begin
        nxt_st = st_ff;
        if (reg_rd_i) begin
            nxt_st.rdata = rd_mux;
        end
        // [R01] low threshold store
        if (wr_low_hi) begin
            nxt_st.low_limit_upper_bits = reg_wdata_i;
        end
        if (wr_low_lo) begin
            nxt_st.low_limit_lower_bits = reg_wdata_i[remote_limit_pkg::LOW_LO_MSB:remote_limit_pkg::LOW_LO_LSB];
        end
        // [R04] lock after write
        if (wr_crit && !st_ff.crit_locked) begin
            nxt_st.critical_limit_bits = reg_wdata_i;
            if (!limit_override_i) begin
                nxt_st.crit_locked = 1'b1;
            end
        end
        // [R08] spare bit dropped
        if (wr_hyst) begin
            nxt_st.critical_hysteresis_bits = reg_wdata_i[remote_limit_pkg::HYST_MSB:0];
        end
        // [R11] spare bits kept as written
        if (wr_filt) begin
            nxt_st.filt_spare             = reg_wdata_i[remote_limit_pkg::FRSV_MSB:remote_limit_pkg::FRSV_LSB];
            nxt_st.filter_level_select    = reg_wdata_i[remote_limit_pkg::FILT_MSB:remote_limit_pkg::FILT_LSB];
            nxt_st.comparator_mode_select = reg_wdata_i[remote_limit_pkg::CMP_MODE_BIT];
        end
        // [R09] filter level decode
        nxt_st.filt_level = 2'(remote_limit_pkg::decode_filter(nxt_st.filter_level_select));
        // [R15] clear only when gone
        if (status_rd_i && !lc.low_cond) begin
            nxt_st.low_flag = 1'b0;
        end
        if (status_rd_i && !lc.crit_cond) begin
            nxt_st.crit_flag = 1'b0;
        end
        // [R13] low alarm set
        if (lc.done && lc.low_cond) begin
            nxt_st.low_flag = 1'b1;
        end
        // [R14] critical alarm set
        if (lc.done && lc.crit_cond) begin
            nxt_st.crit_flag = 1'b1;
        end
        // [R10] comparator or latched alert
        if (st_ff.comparator_mode_select) begin
            nxt_st.alert = lc.low_cond | lc.crit_cond;
        end else begin
            nxt_st.alert = nxt_st.low_flag | nxt_st.crit_flag;
        end
        // [R06] held critical output
        nxt_st.crit_out = lc.crit_hold;
    end

    // a set arriving with a status read wins, as ordered above
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff                          <= '0;
            st_ff.low_limit_upper_bits     <= remote_limit_pkg::LOW_HI_RST;
            st_ff.low_limit_lower_bits     <= remote_limit_pkg::LOW_LO_RST;
            // [R03] power-on limit
            st_ff.critical_limit_bits      <= remote_limit_pkg::CRIT_RST;
            st_ff.critical_hysteresis_bits <= remote_limit_pkg::HYST_RST;
            st_ff.filter_level_select      <= remote_limit_pkg::FILT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o                  = st_ff.rdata;
    assign remote_low_alarm_flag_o      = st_ff.low_flag;
    assign remote_critical_alarm_flag_o = st_ff.crit_flag;
    assign alert_o                      = st_ff.alert;
    assign critical_output_o            = st_ff.crit_out;
    assign filter_level_select_o        = st_ff.filt_level;
    assign comparator_mode_select_o     = st_ff.comparator_mode_select;
    assign critical_limit_locked_o      = st_ff.crit_locked;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_lock_write;
        wr_crit && !limit_override_i && !st_ff.crit_locked;
    endsequence

    sequence s_later_write;
        wr_crit;
    endsequence

    a_low_store: assert property (wr_low_hi |=> st_ff.low_limit_upper_bits == $past(reg_wdata_i)) // [R01]
        else $error("low threshold high byte not stored");
    a_low_lsb_zero: assert property (reg_rd_i && reg_addr_i == remote_limit_pkg::LOW_LO_OFS
                                     |=> reg_rdata_o[4:0] == 5'h00) // [R02]
        else $error("low threshold unused bits read nonzero");
    a_lock_set: assert property (s_lock_write |=> critical_limit_locked_o) // [R04]
        else $error("critical limit not locked after write");
    a_lock_hold: assert property (s_lock_write ##1 (st_ff.critical_limit_bits == $past(reg_wdata_i))
                                  ##[1:8] s_later_write |=> $stable(st_ff.critical_limit_bits)) // [R04]
        else $error("locked critical limit changed");
    a_hyst_spare: assert property (wr_hyst |=> st_ff.critical_hysteresis_bits == $past(reg_wdata_i[6:0])
                                   ##1 (!$past(reg_rd_i) || reg_rdata_o[7] == 1'b0 || $past(reg_addr_i) != 8'h21)) // [R08]
        else $error("hysteresis write mishandled");
    a_filter_map: assert property (wr_filt && reg_wdata_i[2:1] != 2'h0 && reg_wdata_i[2:1] != 2'h3
                                   |=> filter_level_select_o == 2'(remote_limit_pkg::FILT_MIN)) // [R09]
        else $error("minimal filter codes decoded wrongly");
    a_filt_mid_zero: assert property (reg_rd_i && reg_addr_i == remote_limit_pkg::FILT_OFS
                                      |=> reg_rdata_o[5:3] == 3'h0) // [R12]
        else $error("filter register middle bits read nonzero");
    a_cmp_alert: assert property (comparator_mode_select_o && !(lc.low_cond | lc.crit_cond)
                                  |=> !alert_o) // [R10]
        else $error("comparator mode alert stays without condition");
    a_low_set: assert property (lc.done && lc.low_cond |=> remote_low_alarm_flag_o && alert_o) // [R13]
        else $error("low alarm flag or alert missing");
    // hold bit and condition come from the same conversion, so both outputs rise together
    a_crit_set: assert property (lc.done && lc.crit_cond |=> remote_critical_alarm_flag_o && critical_output_o) // [R14]
        else $error("critical alarm or output missing");
    a_flag_latched: assert property (remote_low_alarm_flag_o && !status_rd_i |=> remote_low_alarm_flag_o) // [R15]
        else $error("low alarm flag dropped without status read");

endmodule : remote_temp_limit_regs

// file: verification/smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
    // clock
    input  wire logic        mclk_i,
    // register port toward the bank
    output logic [7:0]       reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    input  wire logic [7:0]  reg_rdata_i
);
    // idle port at time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // one write strobe; data is scrambled after release so nothing leans on stale values
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk_i);
        reg_addr_o  <= addr;
        reg_wdata_o <= (addr == remote_limit_pkg::FILT_OFS) ? (data & 8'h3F) : data;
        reg_wr_o    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~addr;
        reg_wdata_o <= ~data;
    endtask : write_reg

    // read strobe, then take the registered answer once it has landed
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk_i);
        reg_addr_o <= addr;
        reg_rd_o   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~addr;
        @(posedge mclk_i);
        #1;
        data = reg_rdata_i;
    endtask : read_reg
endmodule : smbus_host_model

// file: verification/remote_temp_limit_regs_bench.sv
`timescale 1ns/1ps
module remote_temp_limit_regs_bench;
    // clock, reset and stimulus
    logic         mclk_i;
    logic         rst_i;
    logic [7:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic         override;
    logic         unsigned_fmt;
    logic         conv_done;
    logic [11:0]  remote_temp;
    logic         status_rd;
    // observed outputs
    logic [7:0]   rdata;
    logic         low_flag;
    logic         crit_flag;
    logic         alert;
    logic         crit_out;
    logic [1:0]   filt_lvl;
    logic         cmp_mode;
    logic         locked;
    int           err_total;
    int           check_count;
    logic [1:0]   fexp;

    remote_temp_limit_regs DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .limit_override_i(override),
        .unsigned_format_select_i(unsigned_fmt), .conv_done_i(conv_done), .remote_temp_i(remote_temp),
        .status_rd_i(status_rd), .remote_low_alarm_flag_o(low_flag),
        .remote_critical_alarm_flag_o(crit_flag), .alert_o(alert), .critical_output_o(crit_out),
        .filter_level_select_o(filt_lvl), .comparator_mode_select_o(cmp_mode),
        .critical_limit_locked_o(locked)
    );

    smbus_host_model host (
        .mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_rdata_i(rdata)
    );

    // 100 ns clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(addr, d);
        chk(d, exp, "register read");
    endtask : rd_chk

    // outputs packed as low flag, critical flag, alert, critical output
    task automatic alarms(input logic [3:0] exp);
        chk({4'h0, low_flag, crit_flag, alert, crit_out}, {4'h0, exp}, "alarm outputs");
    endtask : alarms

    // one conversion pulse, then settle past the two-cycle answer
    task automatic conv(input logic [11:0] t);
        @(posedge mclk_i);
        conv_done   <= 1'b1;
        remote_temp <= t;
        @(posedge mclk_i);
        conv_done   <= 1'b0;
        remote_temp <= ~t;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask : conv

    task automatic stat_rd();
        @(posedge mclk_i);
        status_rd <= 1'b1;
        @(posedge mclk_i);
        status_rd <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : stat_rd

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        err_total++;
        close_out();
    end

    initial begin
        err_total = 0;
        check_count = 0;
        rst_i = 1'b1;
        override = 1'b1;
        unsigned_fmt = 1'b0;
        conv_done = 1'b0;
        remote_temp = 12'h000;
        status_rd = 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd_chk(remote_limit_pkg::LOW_HI_OFS, 8'h00);
        rd_chk(remote_limit_pkg::LOW_LO_OFS, 8'h00);
        rd_chk(remote_limit_pkg::CRIT_OFS, 8'h6E);
        rd_chk(remote_limit_pkg::HYST_OFS, 8'h0A);
        rd_chk(8'h55, 8'h00);
        rd_chk(remote_limit_pkg::FILT_OFS, 8'h00);
        chk({7'h0, locked}, 8'h00, "lock at reset");
        $display("test reset values done");
        host.write_reg(remote_limit_pkg::LOW_LO_OFS, 8'hFF);
        rd_chk(remote_limit_pkg::LOW_LO_OFS, 8'hE0);
        host.write_reg(remote_limit_pkg::HYST_OFS, 8'h85);
        rd_chk(remote_limit_pkg::HYST_OFS, 8'h05);
        host.write_reg(remote_limit_pkg::FILT_OFS, 8'hFF);
        rd_chk(remote_limit_pkg::FILT_OFS, 8'h07);
        chk({7'h0, cmp_mode}, 8'h01, "comparator bit");
        for (int i = 0; i < 4; i++) begin
            host.write_reg(remote_limit_pkg::FILT_OFS, {5'h0, 2'(i), 1'b0});
            rd_chk(remote_limit_pkg::FILT_OFS, {5'h0, 2'(i), 1'b0});
            fexp = (i == 0) ? 2'(remote_limit_pkg::FILT_OFF) :
                   (i == 3) ? 2'(remote_limit_pkg::FILT_MAX) : 2'(remote_limit_pkg::FILT_MIN);
            chk({6'h0, filt_lvl}, {6'h0, fexp}, "filter level");
        end
        $display("test mode register done");
        // low limit 25.0 degrees, readings of 20 and 30 degrees
        host.write_reg(remote_limit_pkg::LOW_HI_OFS, 8'h19);
        host.write_reg(remote_limit_pkg::LOW_LO_OFS, 8'h00);
        conv(12'h0A0);
        alarms(4'b1010);
        stat_rd();
        alarms(4'b1010);
        conv(12'h0F0);
        alarms(4'b1010);
        stat_rd();
        alarms(4'b0000);
        $display("test low alarm done");
        // limit 110, hysteresis 5: release only below 105 degrees
        conv(12'h378);
        alarms(4'b0111);
        conv(12'h350);
        stat_rd();
        alarms(4'b0001);
        conv(12'h340);
        alarms(4'b0000);
        conv(12'h370);
        alarms(4'b0000);
        $display("test critical alarm done");
        // 0xF6 is minus ten signed but 246 unsigned; 32 degrees keeps clear of the low threshold
        host.write_reg(remote_limit_pkg::CRIT_OFS, 8'hF6);
        conv(12'h100);
        alarms(4'b0111);
        unsigned_fmt <= 1'b1;
        conv(12'h100);
        stat_rd();
        alarms(4'b0000);
        $display("test limit format done");
        override <= 1'b0;
        host.write_reg(remote_limit_pkg::CRIT_OFS, 8'h70);
        rd_chk(remote_limit_pkg::CRIT_OFS, 8'h70);
        chk({7'h0, locked}, 8'h01, "lock set");
        host.write_reg(remote_limit_pkg::CRIT_OFS, 8'h50);
        rd_chk(remote_limit_pkg::CRIT_OFS, 8'h70);
        $display("test limit lock done");
        // comparator mode: alert drops with the condition while the flag stays
        host.write_reg(remote_limit_pkg::FILT_OFS, 8'h01);
        conv(12'h0A0);
        alarms(4'b1010);
        conv(12'h0F0);
        alarms(4'b1000);
        stat_rd();
        alarms(4'b0000);
        $display("test comparator mode done");
        close_out();
    end
endmodule : remote_temp_limit_regs_bench
